// *** core/pattern_gen.sv ***
// expected test pattern generator (lfsr plus position counter)
// assumes load and advance never together with conflicting intent
`timescale 1ns/1ps
`default_nettype none
module pattern_gen
  import rx_selftest_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  pattern_if.gen pat
);
  logic [7:0] lfsr_reg, lfsr_next;
  logic [7:0] pos_reg, pos_next;

  always_comb begin
    lfsr_next = lfsr_reg;
    pos_next = pos_reg;
    if (pat.load) begin
      lfsr_next = LFSR_SEED;
      pos_next = 8'h01;
    end else if (pat.advance) begin
      lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ LFSR_TAPS) : (lfsr_reg >> 1);
      pos_next = (pos_reg == SEQ_LEN) ? 8'h00 : pos_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lfsr_reg <= LFSR_SEED;
      pos_reg <= 8'h00;
    end else begin
      lfsr_reg <= lfsr_next;
      pos_reg <= pos_next;
    end
  end

  // position zero expects the sequence start character
  assign pat.expected = (pos_reg == 8'h00) ? SEQ_FIRST_CHAR : lfsr_reg;
  assign pat.last = (pos_reg == SEQ_LEN);
endmodule
`default_nettype wire

// *** core/pattern_if.sv ***
// carrier between the state machine and the pattern generator
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface pattern_if;
  logic load;
  logic advance;
  logic [7:0] expected;
  logic last;
  modport ctrl (output load, output advance, input expected, input last);
  modport gen (input load, input advance, output expected, output last);
endinterface
`default_nettype wire

// *** core/rx_selftest_pkg.sv ***
// constants and types for the receive self-test status block
// assumes a single 200 MHz clock domain
package rx_selftest_pkg;
  // status codes on the receive status bus
  localparam logic [2:0] ST_DATA_OK = 3'h0;
  localparam logic [2:0] ST_CMD_OK = 3'h1;
  localparam logic [2:0] ST_LAST_GOOD = 3'h2;
  localparam logic [2:0] ST_LAST_BAD = 3'h4;
  localparam logic [2:0] ST_START = 3'h5;
  localparam logic [2:0] ST_MISMATCH = 3'h6;
  localparam logic [2:0] ST_WAIT = 3'h7;
  // first character of a test sequence (data zero)
  localparam logic [7:0] SEQ_FIRST_CHAR = 8'h00;
  localparam logic [7:0] LFSR_SEED = 8'hFF;
  localparam logic [7:0] LFSR_TAPS = 8'hB8;
  localparam logic [7:0] SEQ_LEN = 8'hFF;
  // error lead over matches that forces a resync
  localparam logic [5:0] ERR_LEAD_LIMIT = 6'h10;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  // recentering time of the elasticity buffer in characters
  localparam logic [3:0] RECENTER_CHARS = 4'h9;
  typedef enum logic [3:0] {
    S_START = 4'b0001,
    S_WAIT = 4'b0010,
    S_COMPARE = 4'b0100,
    S_RECENTER = 4'b1000
  } selftest_state_e;
endpackage

// *** core/rx_selftest_status.sv ***
// receive self-test status state machine, one channel
// assumes decoded characters arrive synchronous to ref_clk with a strobe
`timescale 1ns/1ps
`default_nettype none
module rx_selftest_status
  import rx_selftest_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic selftest_enable,
  input wire logic pll_locked,
  input wire logic buffer_fault,
  input wire logic char_valid,
  input wire logic [7:0] char_data,
  input wire logic char_is_command,
  output logic [2:0] receive_status_bus,
  output logic status_valid
);
  pattern_if pat ();

  pattern_gen u_gen (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pat(pat)
  );

  // ----------------------------------------
  // decode of the channel conditions
  // ----------------------------------------
  selftest_state_e state_reg, state_next;
  logic [5:0] err_reg, err_next;
  logic [5:0] match_reg, match_next;
  logic [3:0] recenter_reg, recenter_next;
  logic [2:0] status_reg, status_next;
  logic valid_reg, valid_next;
  logic hit;
  logic [6:0] lead;
  logic abort_start;
  logic abort_fault;
  logic take;
  logic seq_start;
  logic resync;
  logic clear_cnt;

  assign hit = (char_data == pat.expected);
  // counters saturate; a wider lead only needs to pass the limit
  assign lead = {1'b0, err_reg} - {1'b0, match_reg};
  // lock loss outranks a buffer fault; both report start
  assign abort_start = !selftest_enable || !pll_locked;
  assign abort_fault = !abort_start && buffer_fault;
  assign take = char_valid && !abort_start && !buffer_fault;
  assign seq_start = (char_data == SEQ_FIRST_CHAR) && !char_is_command;
  assign resync = !hit && !lead[6] && (lead[5:0] >= ERR_LEAD_LIMIT);

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    pat.load = 1'b0;
    pat.advance = 1'b0;
    if (abort_start) begin
      state_next = S_START;
    end else if (abort_fault) begin
      state_next = S_RECENTER;
    end else if (char_valid) begin
      unique case (state_reg)
        S_START: begin
          state_next = S_WAIT;
        end
        S_RECENTER: begin
          // hold start until the buffer has recentered
          if (recenter_reg == 4'h1) begin
            state_next = S_WAIT;
          end
        end
        S_WAIT: begin
          if (seq_start) begin
            state_next = S_COMPARE;
            pat.load = 1'b1;
          end
        end
        S_COMPARE: begin
          pat.advance = 1'b1;
          if (resync) begin
            state_next = S_WAIT;
          end
        end
        default: begin
          state_next = S_START;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= S_START;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // error and match counters
  // ----------------------------------------
  // the difference check restarts from zero in start and wait
  assign clear_cnt = abort_start || abort_fault ||
    (take && state_next == S_WAIT && state_reg != S_WAIT);

  always_comb begin
    err_next = err_reg;
    match_next = match_reg;
    if (clear_cnt) begin
      err_next = '0;
      match_next = '0;
    end else if (take && state_reg == S_COMPARE) begin
      if (hit) begin
        if (match_reg != CNT_MAX) begin
          match_next = match_reg + 6'h01;
        end
      end else if (err_reg != CNT_MAX) begin
        err_next = err_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      err_reg <= '0;
      match_reg <= '0;
    end else begin
      err_reg <= err_next;
      match_reg <= match_next;
    end
  end

  // ----------------------------------------
  // recenter count
  // ----------------------------------------
  always_comb begin
    recenter_next = recenter_reg;
    if (abort_fault) begin
      recenter_next = RECENTER_CHARS;
    end else if (take && state_reg == S_RECENTER) begin
      recenter_next = recenter_reg - 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      recenter_reg <= '0;
    end else begin
      recenter_reg <= recenter_next;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always_comb begin
    status_next = status_reg;
    valid_next = 1'b0;
    if (abort_start || abort_fault) begin
      status_next = ST_START;
    end else if (take) begin
      valid_next = 1'b1;
      unique case (state_reg)
        S_START: begin
          status_next = ST_START;
        end
        S_RECENTER: begin
          status_next = ST_START;
        end
        S_WAIT: begin
          status_next = seq_start ? ST_DATA_OK : ST_WAIT;
        end
        S_COMPARE: begin
          if (pat.last) begin
            status_next = hit ? ST_LAST_GOOD : ST_LAST_BAD;
          end else if (!hit) begin
            status_next = ST_MISMATCH;
          end else if (char_is_command) begin
            status_next = ST_CMD_OK;
          end else begin
            status_next = ST_DATA_OK;
          end
        end
        default: begin
          status_next = ST_START;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_reg <= ST_START;
      valid_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      valid_reg <= valid_next;
    end
  end

  assign receive_status_bus = status_reg;
  assign status_valid = valid_reg;
endmodule
`default_nettype wire

// *** verification/host_sampler.sv ***
// host model: registers status and the valid strobe on every clock
// assumes the status block's clock
`timescale 1ns/1ps
`default_nettype none
module host_sampler (
  input wire logic ref_clk,
  input wire logic [2:0] receive_status_bus,
  input wire logic status_valid,
  output logic [2:0] host_code,
  output logic host_strobe
);
  // both link ends share this setting; middle level for send-only ends
  localparam logic [1:0] RECEIVE_CLOCK_SELECT = 2'h1;
  always_ff @(posedge ref_clk) begin
    host_strobe <= status_valid;
    host_code <= receive_status_bus;
  end
endmodule
`default_nettype wire

// *** verification/rx_status_sva.sv ***
// checker for the status block ports
// assumes one clock and a sync reset
`timescale 1ns/1ps
`default_nettype none
module rx_status_sva
  import rx_selftest_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic selftest_enable,
  input wire logic pll_locked,
  input wire logic buffer_fault,
  input wire logic char_valid,
  input wire logic [7:0] char_data,
  input wire logic char_is_command,
  input wire logic [2:0] receive_status_bus,
  input wire logic status_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic ok = selftest_enable && pll_locked && !buffer_fault;
  AST_TAKE: assert property (char_valid && ok |=> status_valid)
    else $error("status strobe missing");
  AST_IDLE: assert property (!(char_valid && ok) |=> !status_valid)
    else $error("stray status strobe");
  AST_STAND: assert property (!char_valid && ok |=> $stable(receive_status_bus))
    else $error("status moved while idle");
  AST_CODE: assert property (status_valid |-> receive_status_bus != 3'h3)
    else $error("reserved status code");
  AST_LOCK: assert property (!pll_locked |=> receive_status_bus == ST_START && !status_valid)
    else $error("lock loss not forcing start");
  AST_FAULT: assert property (buffer_fault |=> receive_status_bus == ST_START)
    else $error("buffer fault not forcing start");
  AST_OFF: assert property (!selftest_enable |=> receive_status_bus == ST_START)
    else $error("disabled status not start");
  AST_RST: assert property (disable iff (1'b0) sys_rst |=> receive_status_bus == ST_START && !status_valid)
    else $error("reset status wrong");
  AST_SEQ: assert property (status_valid && receive_status_bus == ST_WAIT |-> $past(char_data) != SEQ_FIRST_CHAR || $past(char_is_command))
    else $error("first char left in wait");
  cover property (status_valid && receive_status_bus == ST_MISMATCH);
  cover property (status_valid && receive_status_bus == ST_WAIT);
  cover property (status_valid && receive_status_bus == ST_DATA_OK);
  cover property (status_valid && receive_status_bus == ST_LAST_GOOD);
endmodule
bind rx_selftest_status rx_status_sva chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .selftest_enable(selftest_enable), .pll_locked(pll_locked),
  .buffer_fault(buffer_fault), .char_valid(char_valid), .char_data(char_data),
  .char_is_command(char_is_command),
  .receive_status_bus(receive_status_bus), .status_valid(status_valid));
`default_nettype wire

// *** verification/tb_top.sv ***
// testbench: drives characters, checks codes seen by the host model
// assumes one cycle status latency at the design, one more at the host
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
  import rx_selftest_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, selftest_enable = 1'b1, pll_locked = 1'b1;
  logic buffer_fault = 1'b0, char_valid = 1'b0, status_valid, host_strobe;
  logic [7:0] char_data = 8'h00;
  logic char_is_command = 1'b0;
  logic [7:0] lfsr;
  logic [2:0] code;
  logic c;
  logic [2:0] receive_status_bus, host_code;
  logic [3:0] exp_q[$], e;
  int n_errors = 0, check_count = 0, cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  rx_selftest_status uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .selftest_enable(selftest_enable), .pll_locked(pll_locked),
    .buffer_fault(buffer_fault), .char_valid(char_valid), .char_data(char_data),
    .char_is_command(char_is_command), .receive_status_bus(receive_status_bus),
    .status_valid(status_valid));
  host_sampler host (.ref_clk(ref_clk), .receive_status_bus(receive_status_bus),
    .status_valid(status_valid), .host_code(host_code), .host_strobe(host_strobe));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] rnd();
    return 8'($urandom_range(255, 1));
  endfunction
  // bit 3 of a note marks a code left open by the hand-over
  task automatic send(input logic [7:0] d, input logic [3:0] x,
    input logic k = 1'b0);
    @(posedge ref_clk);
    #1;
    char_valid = 1'b1;
    char_data = d;
    char_is_command = k;
    exp_q.push_back(x);
  endtask
  task automatic idle(input int n);
    @(posedge ref_clk);
    #1;
    char_valid = 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic refuse(input int k);
    idle(3);
    pll_locked = (k != 0);
    buffer_fault = (k == 1);
    selftest_enable = (k != 2);
    @(posedge ref_clk);
    #1;
    `CHK("refused", ST_START, receive_status_bus)
    pll_locked = 1'b1;
    buffer_fault = 1'b0;
    selftest_enable = 1'b1;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 3000) begin
      n_errors++;
      end_of_test();
    end
    if (host_strobe === 1'b1) begin
      e = exp_q.pop_front();
      if (!e[3]) `CHK("status", e[2:0], host_code)
    end
  end
  initial begin
    void'($urandom(55196));
    repeat (12) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    send(rnd(), {1'b0, ST_START});
    send(rnd(), {1'b0, ST_WAIT});
    send(SEQ_FIRST_CHAR, {1'b0, ST_DATA_OK});
    for (int i = 0; i < 16; i++) send(8'h00, {1'b0, ST_MISMATCH});
    send(8'h00, {1'b0, ST_MISMATCH});
    send(rnd(), {1'b0, ST_WAIT});
    $display("compare and resync test done");
    send(SEQ_FIRST_CHAR, {1'b0, ST_DATA_OK});
    lfsr = LFSR_SEED;
    for (int i = 1; i < 256; i++) begin
      c = 1'($urandom_range(1, 0));
      code = c ? ST_CMD_OK : ST_DATA_OK;
      if (i == 255) code = ST_LAST_GOOD;
      send(lfsr, {1'b0, code}, c);
      lfsr = lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
    end
    send(SEQ_FIRST_CHAR, {1'b0, ST_DATA_OK});
    $display("full sequence test done");
    refuse(0);
    send(rnd(), {1'b0, ST_START});
    send(rnd(), {1'b0, ST_WAIT});
    $display("lock loss test done");
    refuse(1);
    repeat (9) send(rnd(), {1'b0, ST_START});
    send(rnd(), {1'b0, ST_WAIT});
    $display("buffer fault test done");
    refuse(2);
    idle(4);
    $display("disable test done");
    end_of_test();
  end
endmodule
`default_nettype wire
